/* core/timed_sleep_controller.sv */
// Timed sleep controller: slow clock, calibration, sleep counters, alerts
`timescale 1ns/1ps
module timed_sleep_controller (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Register port behind the serial interface
    input wire logic [tsc_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [tsc_pkg::DATA_W-1:0] i_reg_wdata,
    output logic [tsc_pkg::DATA_W-1:0] o_reg_rdata,
    // Slow oscillator pins
    input wire logic i_slow_int,
    input wire logic i_slow_ext,
    // Operating mode and superframe boundary
    input wire logic i_beacon_mode,
    input wire logic i_coordinator,
    input wire logic i_active_end,
    // Power, beacon request and alert outputs
    output logic o_slow_osc_run,
    output logic o_fast_osc_en,
    output logic o_fast_clk_gate,
    output logic o_beacon_send,
    output logic o_sleep_alert_flag,
    output logic o_wake_alert_flag
);
    import tsc_pkg::*;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = (a == r);
    endfunction : hit

    logic wr_q;
    logic [9:0] addr_q;
    logic [7:0] wd_q;
    logic rd_en;
    logic [1:0] src_q;
    logic osc_dis_q;
    logic [DIV_W-1:0] div_q;
    logic [WAKE_W-1:0] wake_q;
    logic [FINE_W-1:0] fine_cfg_q;
    logic [COARSE_W-1:0] coarse_cfg_q;
    logic [SETTLE_W-1:0] settle_cfg_q;
    logic ack_q;
    logic begin_q;
    logic cal_go_q;
    logic [2:0] int_s_q;
    logic [2:0] ext_s_q;
    logic [1:0] pin_lvl_q;
    logic slow_edge;
    logic [DIV_W-1:0] sdiv_q;
    logic slow_tick_q;
    logic [2:0] fdiv_q;
    logic fast_tick_q;
    logic cal_busy_q;
    logic cal_done_q;
    logic [4:0] cal_per_q;
    logic cal_armed_q;
    logic [CAL_W-1:0] cal_acc_q;
    logic [CAL_W-1:0] cal_res_q;
    pwr_state_t st_q;
    logic timing_q;
    logic fine_ph_q;
    logic [COARSE_W-1:0] coarse_q;
    logic [FINE_W-1:0] fine_q;
    logic [SETTLE_W-1:0] settle_q;
    logic interval_end;
    logic restart_hit;
    logic settle_end;
    logic [7:0] rd_d;

    // Register writes are taken one cycle late so decode stays shallow
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_q <= 1'b0;
            addr_q <= 10'h000;
            wd_q <= 8'h00;
        end else begin
            wr_q <= i_reg_wr;
            addr_q <= i_reg_addr;
            wd_q <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_q <= SRC_INTERNAL;
            osc_dis_q <= 1'b0;
            div_q <= 5'h00;
            wake_q <= 11'h000;
            fine_cfg_q <= 16'h0000;
            coarse_cfg_q <= 26'h0000000;
            settle_cfg_q <= 9'h000;
        end else if (wr_q) begin
            if (hit(addr_q, A_SRC_SEL)) src_q <= wd_q[B_SRC_LSB +: 2];
            if (hit(addr_q, A_OSC_CTL)) osc_dis_q <= wd_q[B_OSC_DIS];
            if (hit(addr_q, A_DIVIDER)) div_q <= wd_q[DIV_W-1:0];
            if (hit(addr_q, A_WAKE_LO)) wake_q[7:0] <= wd_q;
            if (hit(addr_q, A_WAKE_HI)) wake_q[10:8] <= wd_q[2:0];
            if (hit(addr_q, A_FINE_LO)) fine_cfg_q[7:0] <= wd_q;
            if (hit(addr_q, A_FINE_HI)) fine_cfg_q[15:8] <= wd_q;
            if (hit(addr_q, A_COARSE0)) coarse_cfg_q[7:0] <= wd_q;
            if (hit(addr_q, A_COARSE1)) coarse_cfg_q[15:8] <= wd_q;
            if (hit(addr_q, A_COARSE2)) coarse_cfg_q[23:16] <= wd_q;
            if (hit(addr_q, A_COARSE3)) coarse_cfg_q[25:24] <= wd_q[1:0];
            if (hit(addr_q, A_SETTLE_LO)) settle_cfg_q[6:0] <= wd_q[6:0];
            if (hit(addr_q, A_SETTLE_HI)) settle_cfg_q[8:7] <= wd_q[B_SETTLE_HI +: 2];
        end
    end

    // Command bits act as one-cycle pulses and never hold a stored value
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
            begin_q <= 1'b0;
            cal_go_q <= 1'b0;
        end else begin
            ack_q <= wr_q && hit(addr_q, A_SETTLE_LO) && wd_q[B_SLEEP_ACK];
            begin_q <= wr_q && hit(addr_q, A_COARSE3) && wd_q[B_BEGIN_COUNT];
            cal_go_q <= wr_q && hit(addr_q, A_CAL_CTL) && wd_q[B_CAL_START];
        end
    end

    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            int_s_q <= 3'h0;
            ext_s_q <= 3'h0;
            pin_lvl_q <= 2'h0;
        end else begin
            int_s_q <= {int_s_q[1:0], i_slow_int};
            ext_s_q <= {ext_s_q[1:0], i_slow_ext};
            pin_lvl_q[0] <= (int_s_q[1] == int_s_q[2]) ? int_s_q[2] : pin_lvl_q[0];
            pin_lvl_q[1] <= (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : pin_lvl_q[1];
        end
    end

    always_comb begin
        slow_edge = 1'b0;
        if (!osc_dis_q) begin
            case (src_q)
                SRC_INTERNAL: slow_edge = int_s_q[1] && int_s_q[2] && !pin_lvl_q[0];
                SRC_EXTERNAL: slow_edge = ext_s_q[1] && ext_s_q[2] && !pin_lvl_q[1];
                default: slow_edge = 1'b0;
            endcase
        end
    end

    // Divisor 0 and 1 both pass every source period
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sdiv_q <= 5'h00;
            slow_tick_q <= 1'b0;
        end else begin
            slow_tick_q <= 1'b0;
            if (slow_edge) begin
                if (sdiv_q + 5'h01 >= div_q) begin
                    sdiv_q <= 5'h00;
                    slow_tick_q <= 1'b1;
                end else begin
                    sdiv_q <= sdiv_q + 5'h01;
                end
            end
        end
    end

    // Fast tick stands for one period of the fast oscillator
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fdiv_q <= 3'h0;
            fast_tick_q <= 1'b0;
        end else begin
            fast_tick_q <= 1'b0;
            if (!o_fast_osc_en) begin
                fdiv_q <= 3'h0;
            end else if (fdiv_q == FAST_LAST) begin
                fdiv_q <= 3'h0;
                fast_tick_q <= 1'b1;
            end else begin
                fdiv_q <= fdiv_q + 3'h1;
            end
        end
    end

    // Calibration waits for a slow tick so the window is whole tick periods
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cal_busy_q <= 1'b0;
            cal_done_q <= 1'b0;
            cal_armed_q <= 1'b0;
            cal_per_q <= 5'h00;
            cal_acc_q <= 20'h00000;
            cal_res_q <= 20'h00000;
        end else if (cal_go_q) begin
            cal_busy_q <= 1'b1;
            cal_done_q <= 1'b0;
            cal_armed_q <= 1'b0;
            cal_per_q <= 5'h00;
            cal_acc_q <= 20'h00000;
        end else if (cal_busy_q) begin
            if (slow_tick_q && !cal_armed_q) begin
                cal_armed_q <= 1'b1;
            end else if (cal_armed_q) begin
                if (fast_tick_q) cal_acc_q <= cal_acc_q + 20'h00001;
                if (slow_tick_q) begin
                    if (cal_per_q == CAL_PERIODS - 5'h01) begin
                        cal_busy_q <= 1'b0;
                        cal_done_q <= 1'b1;
                        cal_res_q <= cal_acc_q;
                    end else begin
                        cal_per_q <= cal_per_q + 5'h01;
                    end
                end
            end
        end
    end

    // Interval timer: coarse phase counts down, then the fine phase
    assign restart_hit = timing_q && !fine_ph_q && (coarse_q == COARSE_W'(wake_q));
    assign interval_end = timing_q && fine_ph_q && (fine_q == 16'h0000);
    assign settle_end = (st_q == ST_SETTLE) && (settle_q == settle_cfg_q);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            timing_q <= 1'b0;
            fine_ph_q <= 1'b0;
            coarse_q <= 26'h0000000;
            fine_q <= 16'h0000;
        end else if (begin_q || (i_beacon_mode && !i_coordinator && i_active_end)
                     || (interval_end && i_beacon_mode && i_coordinator)) begin
            timing_q <= 1'b1;
            fine_ph_q <= 1'b0;
            coarse_q <= coarse_cfg_q;
            fine_q <= i_beacon_mode ? fine_cfg_q : {1'b0, fine_cfg_q[15:1]};
        end else if (interval_end) begin
            timing_q <= 1'b0;
        end else if (timing_q && !fine_ph_q) begin
            if (coarse_q == 26'h0000000) fine_ph_q <= 1'b1;
            else if (slow_tick_q) coarse_q <= coarse_q - 26'h0000001;
        end else if (timing_q && fast_tick_q) begin
            fine_q <= fine_q - 16'h0001;
        end
    end

    // Power sequence
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= ST_AWAKE;
            settle_q <= 9'h000;
        end else begin
            case (st_q)
                ST_AWAKE: begin
                    if (ack_q || (begin_q && !i_beacon_mode)) st_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (restart_hit || interval_end || !timing_q) begin
                        st_q <= ST_SETTLE;
                        settle_q <= 9'h000;
                    end
                end
                ST_SETTLE: begin
                    if (settle_end) st_q <= ST_AWAKE;
                    else if (slow_tick_q) settle_q <= settle_q + 9'h001;
                end
                default: st_q <= ST_AWAKE;
            endcase
        end
    end

    // Alert flags; a new event wins over a clearing read in the same cycle
    assign rd_en = i_reg_rd && hit(i_reg_addr, A_INT_STATUS);
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sleep_alert_flag <= 1'b0;
            o_wake_alert_flag <= 1'b0;
        end else begin
            if (i_beacon_mode && i_active_end) o_sleep_alert_flag <= 1'b1;
            else if (rd_en) o_sleep_alert_flag <= 1'b0;
            if (settle_end) o_wake_alert_flag <= 1'b1;
            else if (rd_en) o_wake_alert_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_slow_osc_run <= 1'b1;
            o_fast_osc_en <= 1'b1;
            o_fast_clk_gate <= 1'b1;
            o_beacon_send <= 1'b0;
        end else begin
            o_slow_osc_run <= !osc_dis_q;
            o_fast_osc_en <= (st_q != ST_SLEEP);
            o_fast_clk_gate <= (st_q == ST_AWAKE);
            o_beacon_send <= interval_end && i_beacon_mode && i_coordinator;
        end
    end

    // Read data; the register file stays readable while asleep
    always_comb begin
        rd_d = 8'h00;
        case (i_reg_addr)
            A_INT_STATUS: rd_d = {o_sleep_alert_flag, o_wake_alert_flag, 6'h00};
            A_SETTLE_LO: rd_d = {1'b0, settle_cfg_q[6:0]};
            A_SETTLE_HI: rd_d = {3'h0, settle_cfg_q[8:7], 3'h0};
            A_SRC_SEL: rd_d = {src_q, 6'h00};
            A_CAL_LO: rd_d = cal_res_q[7:0];
            A_CAL_MID: rd_d = cal_res_q[15:8];
            A_CAL_CTL: rd_d = {cal_done_q, 2'h0, cal_busy_q, cal_res_q[19:16]};
            A_OSC_CTL: rd_d = {7'h00, osc_dis_q};
            A_DIVIDER: rd_d = {3'h0, div_q};
            A_WAKE_LO: rd_d = wake_q[7:0];
            A_WAKE_HI: rd_d = {5'h00, wake_q[10:8]};
            A_FINE_LO: rd_d = fine_cfg_q[7:0];
            A_FINE_HI: rd_d = fine_cfg_q[15:8];
            A_COARSE0: rd_d = coarse_cfg_q[7:0];
            A_COARSE1: rd_d = coarse_cfg_q[15:8];
            A_COARSE2: rd_d = coarse_cfg_q[23:16];
            A_COARSE3: rd_d = {timing_q, 5'h00, coarse_cfg_q[25:24]};
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) o_reg_rdata <= 8'h00;
        else if (i_reg_rd) o_reg_rdata <= rd_d;
    end

    // Checks
    chk_ack_sleeps: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_q == ST_AWAKE && ack_q) |=> ##1 !o_fast_osc_en)
        else $error("acknowledge did not stop fast oscillator");
    chk_sleep_gated: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_q == ST_SLEEP) |=> (!o_fast_osc_en && !o_fast_clk_gate))
        else $error("fast clock active while asleep");
    chk_settle_withheld: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_q == ST_SETTLE) |=> (o_fast_osc_en && !o_fast_clk_gate))
        else $error("fast clock released during settle");
    chk_restart_wakes: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_q == ST_SLEEP && restart_hit) |=> (st_q == ST_SETTLE) ##1 o_fast_osc_en)
        else $error("restart point did not start oscillator");
    chk_wake_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
        settle_end |=> (o_wake_alert_flag && st_q == ST_AWAKE))
        else $error("wake alert missing after settle");
    chk_alert_holds: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_sleep_alert_flag && !rd_en) |=> o_sleep_alert_flag)
        else $error("sleep alert lost without read");
    chk_sleep_alert: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_beacon_mode && i_active_end) |=> o_sleep_alert_flag)
        else $error("sleep alert not raised at boundary");
    chk_ack_self_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ack_q |=> !ack_q)
        else $error("sleep acknowledge did not clear");
    chk_cal_done: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cal_go_q |=> (!cal_done_q && cal_busy_q))
        else $error("calibration start did not clear done");
    chk_cal_store: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(cal_done_q) |-> (cal_res_q == $past(cal_acc_q)))
        else $error("calibration result not stored");
    chk_beacon_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_beacon_send |=> !o_beacon_send)
        else $error("beacon request wider than one cycle");
    chk_half_fine: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (begin_q && !i_beacon_mode) |=> (fine_q == {1'b0, fine_cfg_q[15:1]}))
        else $error("nonbeacon fine count not halved");
    cov_nonbeacon: cover property (@(posedge i_clk) disable iff (!i_resetn)
        (begin_q && !i_beacon_mode) ##[1:1000] o_wake_alert_flag);
    cov_beacon: cover property (@(posedge i_clk) disable iff (!i_resetn)
        o_beacon_send);
    cov_cal: cover property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(cal_done_q));
endmodule : timed_sleep_controller

/* core/tsc_pkg.sv */
// Constants for the timed sleep controller
package tsc_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [9:0] A_INT_STATUS = 10'h031;
    localparam logic [9:0] A_SETTLE_LO = 10'h035;
    localparam logic [9:0] A_SETTLE_HI = 10'h036;
    localparam logic [9:0] A_SRC_SEL = 10'h207;
    localparam logic [9:0] A_CAL_LO = 10'h209;
    localparam logic [9:0] A_CAL_MID = 10'h20A;
    localparam logic [9:0] A_CAL_CTL = 10'h20B;
    localparam logic [9:0] A_OSC_CTL = 10'h211;
    localparam logic [9:0] A_DIVIDER = 10'h220;
    localparam logic [9:0] A_WAKE_LO = 10'h222;
    localparam logic [9:0] A_WAKE_HI = 10'h223;
    localparam logic [9:0] A_FINE_LO = 10'h224;
    localparam logic [9:0] A_FINE_HI = 10'h225;
    localparam logic [9:0] A_COARSE0 = 10'h226;
    localparam logic [9:0] A_COARSE1 = 10'h227;
    localparam logic [9:0] A_COARSE2 = 10'h228;
    localparam logic [9:0] A_COARSE3 = 10'h229;
    // Field positions
    localparam int B_SLEEP_FLAG = 7;
    localparam int B_WAKE_FLAG = 6;
    localparam int B_SLEEP_ACK = 7;
    localparam int B_CAL_DONE = 7;
    localparam int B_CAL_START = 4;
    localparam int B_BEGIN_COUNT = 7;
    localparam int B_SRC_LSB = 6;
    localparam int B_OSC_DIS = 0;
    localparam int B_SETTLE_HI = 3;
    // Source select codes
    localparam logic [1:0] SRC_INTERNAL = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL = 2'h1;
    // Widths and calibration period count
    localparam int CAL_W = 20;
    localparam int COARSE_W = 26;
    localparam int FINE_W = 16;
    localparam int WAKE_W = 11;
    localparam int SETTLE_W = 9;
    localparam int DIV_W = 5;
    localparam logic [4:0] CAL_PERIODS = 5'h10;
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int FAST_PERIOD_NS = 50;
    localparam int FAST_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [2:0] FAST_LAST = 3'(FAST_CYC - 1);
    typedef enum logic [1:0] {
        ST_AWAKE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_SETTLE = 2'b10
    } pwr_state_t;
endpackage : tsc_pkg

/* tb/slow_osc_model.sv */
// Slow oscillator pins as seen by the timed sleep controller
`timescale 1ns/1ps
module slow_osc_model #(
    parameter int INT_HALF_NS = 5000,
    parameter int EXT_HALF_NS = 15264
) (
    // Enable from the controller
    input wire logic i_run,
    // Oscillator pins
    output logic o_int,
    output logic o_ext
);
    // A stopped oscillator rests low, so a stale high level never fakes a tick
    initial begin
        o_int = 1'b0;
        #3;
        forever begin
            #(INT_HALF_NS);
            o_int = i_run ? ~o_int : 1'b0;
        end
    end
    initial begin
        o_ext = 1'b0;
        #7;
        forever begin
            #(EXT_HALF_NS);
            o_ext = i_run ? ~o_ext : 1'b0;
        end
    end
endmodule : slow_osc_model

/* tb/tb_top.sv */
// Self-checking testbench for the timed sleep controller
`timescale 1ns/1ps
module tb_top;
    import tsc_pkg::*;
    localparam int INT_P = 1250;
    localparam int EXT_P = 3816;
    localparam int CAL_EXP = 16 * INT_P / FAST_CYC;
    logic i_clk, i_resetn, i_reg_wr, i_reg_rd, i_beacon_mode, i_coordinator, i_active_end;
    logic [9:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, rv;
    logic i_slow_int, i_slow_ext, o_slow_osc_run, o_fast_osc_en, o_fast_clk_gate;
    logic o_beacon_send, o_sleep_alert_flag, o_wake_alert_flag, settled;
    logic [19:0] cal;
    int n_errors = 0, num_checks = 0, cyc = 0, n;

    timed_sleep_controller dut (.i_clk, .i_resetn, .i_reg_addr, .i_reg_wr, .i_reg_rd,
        .i_reg_wdata, .o_reg_rdata, .i_slow_int, .i_slow_ext, .i_beacon_mode,
        .i_coordinator, .i_active_end, .o_slow_osc_run, .o_fast_osc_en, .o_fast_clk_gate,
        .o_beacon_send, .o_sleep_alert_flag, .o_wake_alert_flag);
    slow_osc_model #(.INT_HALF_NS(INT_P * 4), .EXT_HALF_NS(EXT_P * 4)) osc (
        .i_run(o_slow_osc_run), .o_int(i_slow_int), .o_ext(i_slow_ext));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic rng(input int got, input int lo, input int hi, input string msg);
        num_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: %s %0d not in %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask : rng

    task automatic do_reset(input logic bm, input logic co);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        i_beacon_mode <= bm;
        i_coordinator <= co;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        #1 d = o_reg_rdata;
    endtask : rd

    // Fast oscillator still runs 2 cycles after the strobe edge and is off at 3
    task automatic off_check();
        #1 chk(8'(o_fast_osc_en), 8'h01, "osc early");
        @(posedge i_clk);
        #1 chk(8'(o_fast_osc_en), 8'h00, "osc off");
    endtask : off_check

    task automatic wait_gate(output int c);
        c = 0;
        do begin
            @(posedge i_clk);
            #1 c++;
            if (o_fast_osc_en === 1'b1 && o_fast_clk_gate === 1'b0) settled = 1'b1;
        end while (o_fast_clk_gate !== 1'b1 && c < 25000);
    endtask : wait_gate

    task automatic wait_beacon(output int c);
        c = 0;
        do begin
            @(posedge i_clk);
            #1 c++;
        end while (o_beacon_send !== 1'b1 && c < 8000);
    endtask : wait_beacon

    task automatic sleep_run(input logic [1:0] s, input logic [4:0] dv, input int p);
        do_reset(1'b0, 1'b0);
        wr(A_SRC_SEL, {s, 6'h00});
        wr(A_DIVIDER, {3'h0, dv});
        wr(A_COARSE0, 8'h04);
        wr(A_WAKE_LO, 8'h02);
        wr(A_SETTLE_LO, 8'h02);
        wr(A_COARSE3, 8'h80);
        off_check();
        rd(A_SRC_SEL, rv);
        chk(rv, {s, 6'h00}, "kept asleep");
        settled = 1'b0;
        wait_gate(n);
        // Two ticks down to the restart point, then two settle ticks
        rng(n, (5 * p) / 2, (9 * p) / 2, "sleep length");
        chk(8'(settled), 8'h01, "settle gap");
        chk(8'(o_wake_alert_flag), 8'h01, "wake flag");
        $display("test sleep src %b div %0d done", s, dv);
    endtask : sleep_run

    initial begin
        i_resetn = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 10'h000;
        i_reg_wdata = 8'h00;
        i_beacon_mode = 1'b0;
        i_coordinator = 1'b0;
        i_active_end = 1'b0;
        do_reset(1'b0, 1'b0);
        #1 chk(8'(o_slow_osc_run), 8'h01, "osc run");
        chk({5'h00, o_fast_osc_en, o_fast_clk_gate, o_sleep_alert_flag}, 8'h06, "outs");
        rd(A_SRC_SEL, rv);
        chk(rv, 8'h80, "source reset");
        rd(A_DIVIDER, rv);
        chk(rv, 8'h00, "divisor reset");
        wr(A_OSC_CTL, 8'h01);
        @(posedge i_clk);
        #1 chk(8'(o_slow_osc_run), 8'h00, "osc stop");
        rd(A_OSC_CTL, rv);
        chk(rv, 8'h01, "osc ctl");
        wr(A_OSC_CTL, 8'h00);
        @(posedge i_clk);
        #1 chk(8'(o_slow_osc_run), 8'h01, "osc restart");
        wr(A_CAL_LO, 8'h5A);
        rd(A_CAL_LO, rv);
        chk(rv, 8'h00, "read-only");
        rd(10'h3FF, rv);
        chk(rv, 8'h00, "unmapped");
        $display("test registers done");

        wr(A_CAL_CTL, 8'h10);
        rd(A_CAL_CTL, rv);
        chk(rv & 8'h90, 8'h10, "cal busy");
        n = 0;
        do begin
            rd(A_CAL_CTL, rv);
            n++;
        end while (rv[7] !== 1'b1 && n < 15000);
        chk(rv & 8'h90, 8'h80, "cal done");
        cal[19:16] = rv[3:0];
        rd(A_CAL_MID, rv);
        cal[15:8] = rv;
        rd(A_CAL_LO, rv);
        cal[7:0] = rv;
        rng(int'(cal), CAL_EXP - 4, CAL_EXP + 4, "cal count");
        $display("test calibration done");

        do_reset(1'b1, 1'b0);
        wr(A_COARSE0, 8'h04);
        wr(A_WAKE_LO, 8'h02);
        @(posedge i_clk) i_active_end <= 1'b1;
        @(posedge i_clk) i_active_end <= 1'b0;
        @(posedge i_clk);
        #1 chk(8'(o_sleep_alert_flag), 8'h01, "sleep alert");
        rd(A_INT_STATUS, rv);
        chk(rv & 8'hC0, 8'h80, "status");
        chk(8'(o_sleep_alert_flag), 8'h00, "alert cleared");
        wr(A_SETTLE_LO, 8'h81);
        off_check();
        rd(A_SETTLE_LO, rv);
        chk(rv & 8'h80, 8'h00, "ack self clear");
        settled = 1'b0;
        wait_gate(n);
        // Two ticks of the inactive period down to the restart point, then one settle tick
        rng(n, (3 * INT_P) / 2, (7 * INT_P) / 2, "inactive period");
        chk(8'(settled), 8'h01, "settle gap");
        rd(A_INT_STATUS, rv);
        chk(rv & 8'hC0, 8'h40, "wake status");
        $display("test alerts done");

        do_reset(1'b1, 1'b1);
        wr(A_COARSE0, 8'h02);
        wr(A_FINE_LO, 8'h64);
        wr(A_COARSE3, 8'h80);
        wait_beacon(n);
        wait_beacon(n);
        rng(n, INT_P + 100 * FAST_CYC, 2 * INT_P + 100 * FAST_CYC + 50, "beacon");
        $display("test beacon done");

        sleep_run(SRC_INTERNAL, 5'h00, INT_P);
        sleep_run(SRC_INTERNAL, 5'h02, 2 * INT_P);
        sleep_run(SRC_EXTERNAL, 5'h00, EXT_P);
        results();
    end
endmodule : tb_top
